// [src/bsu_map.svh]
// timing counts and field positions for the branch, skip, bit and shift unit
// assumes a status byte laid out carry in bit 0 up to interrupt enable in bit 7
`ifndef BSU_MAP_SVH
`define BSU_MAP_SVH

// status byte bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// widths
`define PC_W   16
`define OFS_W  7

// cycle counts of each outcome
`define CYC_NOT_TAKEN  2'h1
`define CYC_BR_TAKEN   2'h2
`define CYC_SKIP_ONE   2'h2
`define CYC_SKIP_TWO   2'h3
`define CYC_IO_BIT     2'h2
`define CYC_SHIFT      2'h1

// program counter steps
`define PC_STEP_ONE    16'h0001
`define PC_STEP_TWO    16'h0002
`define PC_STEP_THREE  16'h0003

// reset values
`define PC_RST         16'h0000
`define BYTE_RST       8'h00

`endif

// [src/bsu_pkg.sv]
// types shared by the branch, skip, bit and shift unit
// assumes the core decoder hands over one operation code per instruction
package bsu_pkg;

  typedef enum logic [4:0] {
    OP_NONE,
    SKIP_IF_REG_BIT_ONE,
    SKIP_IF_IO_BIT_ZERO,
    SKIP_IF_IO_BIT_ONE,
    BRANCH_ON_FLAG_ONE,
    BRANCH_ON_FLAG_ZERO,
    BRANCH_IF_EQUAL,
    BRANCH_IF_UNEQUAL,
    BRANCH_IF_CARRY_ONE,
    BRANCH_IF_CARRY_ZERO,
    BRANCH_IF_SAME_OR_HIGHER,
    BRANCH_IF_LOWER,
    BRANCH_IF_MINUS,
    BRANCH_IF_PLUS,
    BRANCH_SIGNED_GE,
    BRANCH_SIGNED_LT,
    BRANCH_HALF_CARRY_ONE,
    BRANCH_HALF_CARRY_ZERO,
    BRANCH_TRANSFER_BIT_ONE,
    BRANCH_TRANSFER_BIT_ZERO,
    BRANCH_OVERFLOW_ONE,
    BRANCH_OVERFLOW_ZERO,
    BRANCH_IRQ_ENABLED,
    BRANCH_IRQ_DISABLED,
    IO_BIT_SET,
    IO_BIT_CLEAR,
    SHIFT_LEFT_LOGICAL,
    SHIFT_RIGHT_LOGICAL,
    ROTATE_LEFT_VIA_CARRY,
    ROTATE_RIGHT_VIA_CARRY
  } op_type;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } state_type;

endpackage

// [src/shift_flag_unit.sv]
// shift and rotate datapath with its flag results
// assumes operand and carry are stable while the caller samples the result
`timescale 1ns/10ps
`include "bsu_map.svh"

module shift_flag_unit
  import bsu_pkg::*;
(
  // operation
  input  wire op_type     op,
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  // result
  output logic      [7:0] result,
  output logic            carry_out,
  output logic            zero_out,
  output logic            neg_out,
  output logic            ovf_out
);

  always_comb begin
    result    = operand;
    carry_out = carry_in;
    unique case (op)
      SHIFT_LEFT_LOGICAL: begin
        result    = {operand[6:0], 1'b0};
        carry_out = operand[7];
      end
      SHIFT_RIGHT_LOGICAL: begin
        result    = {1'b0, operand[7:1]};
        carry_out = operand[0];
      end
      ROTATE_LEFT_VIA_CARRY: begin
        result    = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      ROTATE_RIGHT_VIA_CARRY: begin
        result    = {carry_in, operand[7:1]};
        carry_out = operand[0];
      end
      default: begin
        result    = operand;
        carry_out = carry_in;
      end
    endcase
    zero_out = (result == `BYTE_RST);
    neg_out  = result[7];
    // overflow of a one-place shift is n xor c, which is the sign change only for the left shifts
    ovf_out  = result[7] ^ carry_out;
  end

endmodule // shift_flag_unit

// [src/bsu_core.sv]
// branch, skip, single-bit and shift execution for the 8-bit core
// assumes operands are valid in the cycle START is high and the core
// commits PC, I/O, register and status writes on the strobes below
//
// Functional notes
// - skip on register bit one: pc plus 2 or 3, no flags
// - skip on I/O bit zero: pc plus 2 or 3, no flags
// - skip on I/O bit one: pc plus 2 or 3, no flags
// - branch on chosen status bit one: pc plus k plus one
// - branch on chosen status bit zero: one cycle idle, two taken
// - branch if equal when zero flag is one, one or two cycles
// - carry branches: lower/carry-one on c one, others on c zero
// - minus branch on n one, plus branch on n zero
// - signed ge on n xor v zero, signed lt on one
// - half carry branches on h one or zero
// - transfer bit branches on t one or zero
// - overflow branches on v one or zero
// - interrupt branches on i one or zero, no flags changed
// - I/O bit set forces chosen bit to one, two cycles
// - I/O bit clear forces chosen bit to zero, two cycles
// - logical left shift, zero into bit 0, z c n v in one cycle
// - logical right shift, zero into bit 7, z c n v in one cycle
// - rotate left through carry, z c n v in one cycle
// - rotate right through carry, z c n v in one cycle
`timescale 1ns/10ps
`include "bsu_map.svh"

module bsu_core
  import bsu_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_B,
  // request
  input  wire logic              START,
  input  wire op_type            OP,
  input  wire logic [2:0]        BIT_SEL,
  input  wire logic [`OFS_W-1:0] OFFSET,
  input  wire logic              NEXT_TWO_WORD,
  // operands
  input  wire logic [`PC_W-1:0]  PC_IN,
  input  wire logic [7:0]        REG_VAL,
  input  wire logic [7:0]        IO_VAL,
  input  wire logic [7:0]        STATUS_IN,
  // handshake
  output logic                   BUSY,
  output logic                   DONE,
  // results
  output logic                   PC_LOAD,
  output logic [`PC_W-1:0]       PC_OUT,
  output logic                   IO_WE,
  output logic [7:0]             IO_WDATA,
  output logic                   REG_WE,
  output logic [7:0]             REG_WDATA,
  output logic                   STATUS_WE,
  output logic [7:0]             STATUS_OUT
);

  state_type        state_r,     state_nxt;
  logic [1:0]       cnt_r,       cnt_nxt;
  logic [`PC_W-1:0] pc_r,        pc_nxt;
  logic [7:0]       io_r,        io_nxt;
  logic [7:0]       reg_r,       reg_nxt;
  logic [7:0]       stat_r,      stat_nxt;
  logic             pc_we_r,     pc_we_nxt;
  logic             io_we_r,     io_we_nxt;
  logic             reg_we_r,    reg_we_nxt;
  logic             stat_we_r,   stat_we_nxt;

  logic             take;
  logic             is_branch;
  logic             is_skip;
  logic             is_io;
  logic             is_shift;
  logic [2:0]       flag_idx;
  logic             flag_pol;
  logic             br_cond;
  logic             skip_cond;
  logic [7:0]       bit_mask;
  logic [`PC_W-1:0] k_ext;
  logic [7:0]       sh_result;
  logic             sh_c;
  logic             sh_z;
  logic             sh_n;
  logic             sh_v;

  // one-hot mask of the selected bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      assign bit_mask[gi] = (BIT_SEL == 3'(gi));
    end
  endgenerate

  shift_flag_unit shift_flag_unit_inst (
    .op        (OP),
    .operand   (REG_VAL),
    .carry_in  (STATUS_IN[`FLAG_C]),
    .result    (sh_result),
    .carry_out (sh_c),
    .zero_out  (sh_z),
    .neg_out   (sh_n),
    .ovf_out   (sh_v)
  );

  // a new request may land in the completing cycle, so no dead cycle
  assign BUSY      = (state_r == ST_EXEC) && (cnt_r != 2'h0);
  assign DONE      = (state_r == ST_EXEC) && (cnt_r == 2'h0);
  assign take      = START && !BUSY;
  assign k_ext     = {{(`PC_W-`OFS_W){OFFSET[`OFS_W-1]}}, OFFSET};
  assign PC_LOAD   = DONE && pc_we_r;
  assign IO_WE     = DONE && io_we_r;
  assign REG_WE    = DONE && reg_we_r;
  assign STATUS_WE = DONE && stat_we_r;
  assign PC_OUT     = pc_r;
  assign IO_WDATA   = io_r;
  assign REG_WDATA  = reg_r;
  assign STATUS_OUT = stat_r;

  // decode: class, tested status bit and the level that takes the branch
  always_comb begin
    is_branch = 1'b1;
    is_skip   = 1'b0;
    is_io     = 1'b0;
    is_shift  = 1'b0;
    flag_idx  = `FLAG_Z;
    flag_pol  = !(OP inside {BRANCH_ON_FLAG_ZERO, BRANCH_IF_UNEQUAL,
                  BRANCH_IF_CARRY_ZERO, BRANCH_IF_SAME_OR_HIGHER,
                  BRANCH_IF_PLUS, BRANCH_SIGNED_GE, BRANCH_HALF_CARRY_ZERO,
                  BRANCH_TRANSFER_BIT_ZERO, BRANCH_OVERFLOW_ZERO,
                  BRANCH_IRQ_DISABLED});
    unique case (OP)
      SKIP_IF_REG_BIT_ONE, SKIP_IF_IO_BIT_ZERO, SKIP_IF_IO_BIT_ONE: begin
        is_branch = 1'b0;
        is_skip   = 1'b1;
      end
      BRANCH_ON_FLAG_ONE, BRANCH_ON_FLAG_ZERO: flag_idx = BIT_SEL;
      BRANCH_IF_EQUAL, BRANCH_IF_UNEQUAL: flag_idx = `FLAG_Z;
      BRANCH_IF_CARRY_ONE, BRANCH_IF_LOWER,
      BRANCH_IF_CARRY_ZERO, BRANCH_IF_SAME_OR_HIGHER: flag_idx = `FLAG_C;
      BRANCH_IF_MINUS, BRANCH_IF_PLUS: flag_idx = `FLAG_N;
      BRANCH_SIGNED_LT, BRANCH_SIGNED_GE: flag_idx = `FLAG_S;
      BRANCH_HALF_CARRY_ONE, BRANCH_HALF_CARRY_ZERO: flag_idx = `FLAG_H;
      BRANCH_TRANSFER_BIT_ONE, BRANCH_TRANSFER_BIT_ZERO: flag_idx = `FLAG_T;
      BRANCH_OVERFLOW_ONE, BRANCH_OVERFLOW_ZERO: flag_idx = `FLAG_V;
      BRANCH_IRQ_ENABLED, BRANCH_IRQ_DISABLED: flag_idx = `FLAG_I;
      IO_BIT_SET, IO_BIT_CLEAR: begin
        is_branch = 1'b0;
        is_io     = 1'b1;
      end
      SHIFT_LEFT_LOGICAL, SHIFT_RIGHT_LOGICAL,
      ROTATE_LEFT_VIA_CARRY, ROTATE_RIGHT_VIA_CARRY: begin
        is_branch = 1'b0;
        is_shift  = 1'b1;
      end
      default:                  is_branch = 1'b0;
    endcase
  end

  // signed ops use n xor v directly rather than trusting a stored s bit
  always_comb begin
    if (OP == BRANCH_SIGNED_GE || OP == BRANCH_SIGNED_LT) begin
      br_cond = ((STATUS_IN[`FLAG_N] ^ STATUS_IN[`FLAG_V]) == flag_pol);
    end else begin
      br_cond = (STATUS_IN[flag_idx] == flag_pol);
    end
    unique case (OP)
      SKIP_IF_REG_BIT_ONE: skip_cond = |(REG_VAL & bit_mask);
      SKIP_IF_IO_BIT_ZERO: skip_cond = ~|(IO_VAL & bit_mask);
      SKIP_IF_IO_BIT_ONE:  skip_cond = |(IO_VAL & bit_mask);
      default:             skip_cond = 1'b0;
    endcase
  end

  // next state and results
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    pc_nxt      = pc_r;
    io_nxt      = io_r;
    reg_nxt     = reg_r;
    stat_nxt    = stat_r;
    pc_we_nxt   = pc_we_r;
    io_we_nxt   = io_we_r;
    reg_we_nxt  = reg_we_r;
    stat_we_nxt = stat_we_r;
    if (state_r == ST_EXEC && cnt_r != 2'h0) begin
      cnt_nxt = cnt_r - 2'h1;
    end else if (take && (is_branch || is_skip || is_io || is_shift)) begin
      state_nxt   = ST_EXEC;
      pc_we_nxt   = is_branch || is_skip;
      io_we_nxt   = is_io;
      reg_we_nxt  = is_shift;
      stat_we_nxt = is_shift;
      pc_nxt      = PC_IN + `PC_STEP_ONE;
      cnt_nxt     = `CYC_NOT_TAKEN - 2'h1;
      io_nxt      = IO_VAL;
      reg_nxt     = REG_VAL;
      stat_nxt    = STATUS_IN;
      if (is_branch && br_cond) begin
        // relative target pc plus k plus one
        pc_nxt  = PC_IN + k_ext + `PC_STEP_ONE;
        cnt_nxt = `CYC_BR_TAKEN - 2'h1;
      end else if (is_skip && skip_cond) begin
        // step over one or two words
        pc_nxt  = NEXT_TWO_WORD ? PC_IN + `PC_STEP_THREE
                                : PC_IN + `PC_STEP_TWO;
        cnt_nxt = NEXT_TWO_WORD ? `CYC_SKIP_TWO - 2'h1
                                : `CYC_SKIP_ONE - 2'h1;
      end else if (is_io) begin
        cnt_nxt = `CYC_IO_BIT - 2'h1;
        if (OP == IO_BIT_SET) begin
          io_nxt = IO_VAL | bit_mask;
        end else begin
          io_nxt = IO_VAL & ~bit_mask;
        end
      end else if (is_shift) begin
        // only z c n v move, other status bits pass through
        cnt_nxt             = `CYC_SHIFT - 2'h1;
        reg_nxt             = sh_result;
        stat_nxt[`FLAG_C]   = sh_c;
        stat_nxt[`FLAG_Z]   = sh_z;
        stat_nxt[`FLAG_N]   = sh_n;
        stat_nxt[`FLAG_V]   = sh_v;
      end
    end else begin
      state_nxt = ST_IDLE;
      cnt_nxt   = 2'h0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 2'h0;
      pc_r      <= `PC_RST;
      io_r      <= `BYTE_RST;
      reg_r     <= `BYTE_RST;
      stat_r    <= `BYTE_RST;
      pc_we_r   <= 1'b0;
      io_we_r   <= 1'b0;
      reg_we_r  <= 1'b0;
      stat_we_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      pc_r      <= pc_nxt;
      io_r      <= io_nxt;
      reg_r     <= reg_nxt;
      stat_r    <= stat_nxt;
      pc_we_r   <= pc_we_nxt;
      io_we_r   <= io_we_nxt;
      reg_we_r  <= reg_we_nxt;
      stat_we_r <= stat_we_nxt;
    end
  end

  // checks
  sequence s_take(op_type o);
    take && OP == o;
  endsequence

  sequence s_done_pc(logic [`PC_W-1:0] v);
    DONE && PC_LOAD && PC_OUT == v;
  endsequence

  a_skip_reg_one: assert property (@(posedge CLK) disable iff (!RST_B)
    s_take(SKIP_IF_REG_BIT_ONE) ##0 (REG_VAL[BIT_SEL] && !NEXT_TWO_WORD)
    |-> ##1 (BUSY && !DONE) ##1 s_done_pc($past(PC_IN, 2) + `PC_STEP_TWO))
    else $error("register bit skip wrong");

  a_skip_io_zero: assert property (@(posedge CLK) disable iff (!RST_B)
    s_take(SKIP_IF_IO_BIT_ZERO) ##0 (!IO_VAL[BIT_SEL] && NEXT_TWO_WORD)
    |-> ##3 s_done_pc($past(PC_IN, 3) + `PC_STEP_THREE))
    else $error("io zero skip wrong");

  a_skip_io_miss: assert property (@(posedge CLK) disable iff (!RST_B)
    s_take(SKIP_IF_IO_BIT_ONE) ##0 !IO_VAL[BIT_SEL]
    |=> s_done_pc($past(PC_IN) + `PC_STEP_ONE))
    else $error("io one skip taken wrongly");

  a_branch_equal: assert property (@(posedge CLK) disable iff (!RST_B)
    s_take(BRANCH_IF_EQUAL) ##0 STATUS_IN[`FLAG_Z]
    |-> ##2 s_done_pc($past(PC_IN, 2) + $past(k_ext, 2) + `PC_STEP_ONE))
    else $error("equal branch target wrong");

  a_unequal_miss: assert property (@(posedge CLK) disable iff (!RST_B)
    s_take(BRANCH_IF_UNEQUAL) ##0 STATUS_IN[`FLAG_Z]
    |=> s_done_pc($past(PC_IN) + `PC_STEP_ONE))
    else $error("unequal branch taken on zero set");

  a_signed_ge: assert property (@(posedge CLK) disable iff (!RST_B)
    s_take(BRANCH_SIGNED_GE) ##0 (STATUS_IN[`FLAG_N] == STATUS_IN[`FLAG_V])
    |-> ##1 (BUSY && !DONE) ##1 (DONE && PC_LOAD))
    else $error("signed ge branch timing wrong");

  a_io_set_bit: assert property (@(posedge CLK) disable iff (!RST_B)
    s_take(IO_BIT_SET) |-> ##2 (IO_WE && !STATUS_WE &&
    IO_WDATA == ($past(IO_VAL, 2) | (8'h01 << $past(BIT_SEL, 2)))))
    else $error("io bit set wrong");

  a_shift_left: assert property (@(posedge CLK) disable iff (!RST_B)
    s_take(SHIFT_LEFT_LOGICAL) |=> (REG_WE && STATUS_WE &&
    REG_WDATA == {$past(REG_VAL[6:0]), 1'b0} &&
    STATUS_OUT[`FLAG_C] == $past(REG_VAL[7])))
    else $error("left shift wrong");

  a_rot_right: assert property (@(posedge CLK) disable iff (!RST_B)
    s_take(ROTATE_RIGHT_VIA_CARRY) |=> (REG_WE &&
    REG_WDATA == {$past(STATUS_IN[`FLAG_C]), $past(REG_VAL[7:1])} &&
    STATUS_OUT[`FLAG_C] == $past(REG_VAL[0])))
    else $error("right rotate wrong");

  a_flag_keep: assert property (@(posedge CLK) disable iff (!RST_B)
    DONE && PC_LOAD |-> !STATUS_WE && !IO_WE && !REG_WE)
    else $error("branch or skip touched flags");

endmodule // bsu_core

// [test/tb_branch_skip_bitop_shift_unit.sv]
// self-checking bench for the branch, skip, bit and shift unit
// assumes bsu_core takes one START pulse and answers with DONE
`timescale 1ns/10ps
`include "bsu_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_total++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end

module tb_branch_skip_bitop_shift_unit;
  import bsu_pkg::*;
  logic        clk      = 1'b0;
  logic        rst_b    = 1'b0;
  logic        start    = 1'b0;
  op_type      op       = OP_NONE;
  logic [2:0]  bsel     = 3'h0;
  logic [6:0]  ofs      = 7'h00;
  logic        two      = 1'b0;
  logic [15:0] pc_in    = 16'h0000;
  logic [7:0]  reg_val  = 8'h00;
  logic [7:0]  io_val   = 8'h00;
  logic [7:0]  st_in    = 8'h00;
  logic        busy;
  logic        done;
  logic        pc_load;
  logic [15:0] pc_out;
  logic        io_we;
  logic [7:0]  io_wdata;
  logic        reg_we;
  logic [7:0]  reg_wdata;
  logic        status_we;
  logic [7:0]  status_out;
  int          err_total = 0;
  int          cmp_count = 0;
  int          n_cyc;

  always #5 clk = ~clk;

  bsu_core bsu_core_inst (
    .CLK(clk), .RST_B(rst_b), .START(start), .OP(op), .BIT_SEL(bsel),
    .OFFSET(ofs), .NEXT_TWO_WORD(two), .PC_IN(pc_in), .REG_VAL(reg_val),
    .IO_VAL(io_val), .STATUS_IN(st_in), .BUSY(busy), .DONE(done),
    .PC_LOAD(pc_load), .PC_OUT(pc_out), .IO_WE(io_we), .IO_WDATA(io_wdata),
    .REG_WE(reg_we), .REG_WDATA(reg_wdata), .STATUS_WE(status_we),
    .STATUS_OUT(status_out)
  );

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one request, then wait for DONE; n_cyc counts from the taking edge
  task automatic go(input op_type o, input logic [2:0] b,
                    input logic [6:0] k, input logic tw,
                    input logic [15:0] pc, input logic [7:0] rv,
                    input logic [7:0] iv, input logic [7:0] sv);
    @(posedge clk);
    op      <= o;
    bsel    <= b;
    ofs     <= k;
    two     <= tw;
    pc_in   <= pc;
    reg_val <= rv;
    io_val  <= iv;
    st_in   <= sv;
    start   <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    n_cyc = 1;
    while (done !== 1'b1 && n_cyc < 6) begin
      @(posedge clk);
      #1;
      n_cyc++;
    end
  endtask

  // data outputs only judged when their strobe is expected
  task automatic chk(input string nm, input int cy, input logic pl,
                     input logic [15:0] pc, input logic iw,
                     input logic [7:0] io, input logic rw,
                     input logic [7:0] rv, input logic [7:0] sv);
    `CHK({nm, " cycles"}, cy, n_cyc)
    `CHK({nm, " pc_load"}, pl, pc_load)
    `CHK({nm, " io_we"}, iw, io_we)
    `CHK({nm, " reg_we"}, rw, reg_we)
    `CHK({nm, " status_we"}, rw, status_we)
    if (pl) `CHK({nm, " pc"}, pc, pc_out)
    if (iw) `CHK({nm, " io"}, io, io_wdata)
    if (rw) `CHK({nm, " reg"}, rv, reg_wdata)
    if (rw) `CHK({nm, " status"}, sv, status_out)
  endtask

  task automatic t_reset();
    `CHK("reset done", 1'b0, done)
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset pc", 16'h0000, pc_out)
    $display("test reset done");
  endtask

  // other flags opposite to the tested one, so a wrong pick shows up
  task automatic t_branch();
    op_type ops[18] = '{BRANCH_IF_EQUAL, BRANCH_IF_UNEQUAL,
      BRANCH_IF_CARRY_ONE, BRANCH_IF_CARRY_ZERO, BRANCH_IF_SAME_OR_HIGHER,
      BRANCH_IF_LOWER, BRANCH_IF_MINUS, BRANCH_IF_PLUS, BRANCH_SIGNED_GE,
      BRANCH_SIGNED_LT, BRANCH_HALF_CARRY_ONE, BRANCH_HALF_CARRY_ZERO,
      BRANCH_TRANSFER_BIT_ONE, BRANCH_TRANSFER_BIT_ZERO,
      BRANCH_OVERFLOW_ONE, BRANCH_OVERFLOW_ZERO, BRANCH_IRQ_ENABLED,
      BRANCH_IRQ_DISABLED};
    logic [2:0] fb[18] = '{`FLAG_Z, `FLAG_Z, `FLAG_C, `FLAG_C, `FLAG_C,
      `FLAG_C, `FLAG_N, `FLAG_N, `FLAG_V, `FLAG_V, `FLAG_H, `FLAG_H,
      `FLAG_T, `FLAG_T, `FLAG_V, `FLAG_V, `FLAG_I, `FLAG_I};
    logic pol[18] = '{1, 0, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0};
    logic [6:0] ks[3] = '{7'h7E, 7'h3F, 7'h40};
    logic [7:0] st;
    logic [15:0] e;
    logic tk;
    for (int i = 0; i < 18; i++) begin
      for (int v = 0; v < 2; v++) begin
        st = v ? (8'h01 << fb[i]) : ~(8'h01 << fb[i]);
        // signed forms: N held at one, so N xor V is the inverse of V
        if (i == 8 || i == 9)
          st = 8'h04 | {4'h0, v[0], 3'h0};
        go(ops[i], 3'h0, ks[i%3], 1'b0, 16'h0100, 8'hFF, 8'hFF, st);
        tk = (v[0] == pol[i]);
        e = tk ? 16'h0101 + {{9{ks[i%3][6]}}, ks[i%3]} : 16'h0101;
        chk("branch", tk ? 2 : 1, 1'b1, e, 0, 0, 0, 0,
            0);
      end
    end
    $display("test branch done");
  endtask

  task automatic t_flag();
    logic [7:0] st;
    logic tk;
    for (int s = 0; s < 8; s++) begin
      for (int v = 0; v < 4; v++) begin
        st = v[0] ? (8'h01 << s) : ~(8'h01 << s);
        tk = (v[0] == !v[1]);
        go(v[1] ? BRANCH_ON_FLAG_ZERO : BRANCH_ON_FLAG_ONE, s[2:0], 7'h05,
           1'b0, 16'h0200, 8'h00, 8'h00, st);
        chk("flag branch", tk ? 2 : 1, 1'b1, tk ? 16'h0206 : 16'h0201, 0,
            0, 0, 0, 0);
      end
    end
    $display("test flag branch done");
  endtask

  // the operand not under test carries the inverse pattern
  task automatic t_skip();
    op_type ops[3] = '{SKIP_IF_REG_BIT_ONE, SKIP_IF_IO_BIT_ZERO,
                       SKIP_IF_IO_BIT_ONE};
    logic [7:0] m;
    logic [7:0] val;
    for (int i = 0; i < 3; i++) begin
      for (int b = 0; b < 8; b++) begin
        for (int v = 0; v < 4; v++) begin
          m = 8'h01 << b;
          val = (v[0] ^ (i == 1)) ? m : ~m;
          go(ops[i], b[2:0], 7'h00, v[1], 16'h0300,
             (i == 0) ? val : ~val, (i == 0) ? ~val : val, 8'hFF);
          if (v[0])
            chk("skip", v[1] ? 3 : 2, 1'b1, v[1] ? 16'h0303 : 16'h0302, 0,
                0, 0, 0, 0);
          else
            chk("no skip", 1, 1'b1, 16'h0301, 0, 0, 0, 0,
                0);
        end
      end
    end
    $display("test skip done");
  endtask

  task automatic t_io();
    logic [7:0] m;
    logic [7:0] iv;
    for (int j = 0; j < 2; j++) begin
      for (int b = 0; b < 8; b++) begin
        m = 8'h01 << b;
        iv = b[0] ? 8'hA5 : 8'h5A;
        go(j ? IO_BIT_CLEAR : IO_BIT_SET, b[2:0], 7'h00, 1'b0, 16'h0400,
           8'h00, iv, 8'hFF);
        chk("io bit", 2, 1'b0, 0, 1'b1, j ? (iv & ~m) : (iv | m), 0, 0,
            0);
      end
    end
    $display("test io bit done");
  endtask

  // upper status bits must pass through, lower ones are all rewritten
  task automatic t_shift();
    op_type ops[4] = '{SHIFT_LEFT_LOGICAL, SHIFT_RIGHT_LOGICAL,
                       ROTATE_LEFT_VIA_CARRY, ROTATE_RIGHT_VIA_CARRY};
    logic [7:0] ds[6] = '{8'h00, 8'h80, 8'h81, 8'h40, 8'hFF, 8'h01};
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] st;
    logic co;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 12; j++) begin
        d = ds[j/2];
        st = {4'h6, 3'h5, j[0]};
        case (i)
          0: r = {d[6:0], 1'b0};
          1: r = {1'b0, d[7:1]};
          2: r = {d[6:0], j[0]};
          default: r = {j[0], d[7:1]};
        endcase
        co = (i[0] == 1'b0) ? d[7] : d[0];
        go(ops[i], 3'h0, 7'h00, 1'b0, 16'h0500, d, 8'h00, st);
        chk("shift", 1, 1'b0, 0, 0, 0, 1'b1, r, {st[7:4], r[7] ^ co,
            r[7], r == 8'h00, co});
      end
    end
    $display("test shift done");
  endtask

  // a request held through busy is dropped until the done cycle takes it
  task automatic t_order();
    @(posedge clk);
    op     <= SKIP_IF_IO_BIT_ONE;
    bsel   <= 3'h1;
    two    <= 1'b1;
    pc_in  <= 16'h0700;
    io_val <= 8'h02;
    start  <= 1'b1;
    @(posedge clk);
    op     <= IO_BIT_SET;
    bsel   <= 3'h0;
    io_val <= 8'h00;
    #1;
    `CHK("order busy 1", 1'b1, busy)
    @(posedge clk);
    #1;
    `CHK("order busy 2", 1'b1, busy)
    `CHK("order early", 1'b0, done)
    @(posedge clk);
    #1;
    `CHK("order skip done", 1'b1, done)
    `CHK("order skip pc", 16'h0703, pc_out)
    `CHK("order no io", 1'b0, io_we)
    @(posedge clk);
    start <= 1'b0;
    #1;
    `CHK("order taken", 1'b1, busy)
    `CHK("order not done", 1'b0, done)
    @(posedge clk);
    #1;
    `CHK("order io done", 1'b1, io_we)
    `CHK("order io data", 8'h01, io_wdata)
    $display("test order done");
  endtask

  // an empty operation code must never answer
  task automatic t_none();
    go(OP_NONE, 3'h0, 7'h00, 1'b0, 16'h0600, 8'h00, 8'h00, 8'h00);
    chk("no op", 6, 1'b0, 0, 0, 0, 0, 0, 0);
    $display("test no op done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    t_reset();
    rst_b <= 1'b1;
    t_branch();
    t_flag();
    t_skip();
    t_io();
    t_shift();
    t_order();
    t_none();
    results();
  end

  // whole run is about six hundred cycles; this is far beyond it
  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule // tb_branch_skip_bitop_shift_unit
